// ### core/aan_edge.sv
// Rising edge detector for one request input
`timescale 1ns/10ps
module aan_edge (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic level_in,
    output logic rise_out
);
    logic prev_reg;
    logic prev_next;
    always_comb begin
        prev_next = level_in;
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end
    assign rise_out = level_in & ~prev_reg;
endmodule

// ### core/aan_pkg.sv
// Package of constants and types for the alarm annunciator
package aan_pkg;
    localparam int ALARM_COUNT = 64;
    localparam int SRC_COUNT = 128;
    localparam int SRC_SEL_W = 7;
    localparam int ALARM_IDX_W = 6;
    localparam int FIXED_SLOTS = 16;
    localparam int OBJ_COUNT = 10;
    localparam int OBJ_SEL_W = 4;
    localparam logic [OBJ_SEL_W-1:0] OBJ_DEFAULT = 4'h0;
    localparam int CLK_HZ = 125000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int BLINK_MS = 250;
    localparam int TIMEOUT_W = 12;
    localparam logic [TIMEOUT_W-1:0] TIMEOUT_OFF = 12'h000;
    localparam int MS_PER_S = 1000;
    localparam int TS_W = 32;
    localparam int COLOR_W = 2;
    typedef enum logic [2:0] {
        AAN_IDLE = 3'h1,
        AAN_SCAN = 3'h2,
        AAN_WAIT = 3'h4
    } aan_state_t;
endpackage

// ### core/aan_tick.sv
// Divider that pulses once every DIV cycles
`timescale 1ns/10ps
module aan_tick #(
    parameter int DIV = 125000
) (
    input wire logic clk_sys,
    input wire logic nrst,
    output logic tick_out
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    always_comb begin
        tick_next = 1'b0;
        cnt_next = cnt_reg + 32'h1;
        if (cnt_reg == 32'(DIV - 1)) begin
            cnt_next = 32'h0;
            tick_next = 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_reg <= 32'h0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end
    assign tick_out = tick_reg;
endmodule

// ### core/aan_top.sv
// Alarm annunciator core: alarm states, LEDs, buzzer, records, panel timers
`timescale 1ns/10ps
//
// Operation
// - 64 alarms, each picks one source among digital inputs and logic outputs
// - Source asserted: alarm present, LED steadily on
// - Source gone: alarm stays shown, LED blinks until cleared
// - Clear key clears every alarm whose source is inactive
// - Clear-all input acts exactly like the clear key
// - Single clear clears selected alarm only if its source is inactive
// - Activation with raise mask bit set writes time-stamped raise record
// - Mask selects raise records, fall records or both per alarm
// - Recorded events also offered to the active protocol port
// - Any alarm activation asserts the buzzer output
// - Back key, silence input or mute command drop the buzzer
// - Latch feeding an alarm stays until Reset-latches is issued after a Back key press
// - Reset-latches clears latches of inactive sources only after Back key has been pressed, then the command returns idle
// - No input for programmed time returns default view; zero disables
// - LED test lights all LEDs, multicolour LEDs cycle colours
// - Fixed mode shows slots 1 to 16; dynamic appends on activation
// - Open/close LEDs follow one of ten objects, first by default
// - Fault-register reset input clears the latest fault register
module aan_top
    import aan_pkg::*;
#(
    parameter int NUM_ALARMS = aan_pkg::ALARM_COUNT,
    parameter int TICK_DIV = aan_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [aan_pkg::SRC_COUNT-1:0] src_signals,
    input wire logic [aan_pkg::SRC_SEL_W*aan_pkg::ALARM_COUNT-1:0] src_select,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] src_latched,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] mask_raise,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] mask_fall,
    input wire logic key_clear,
    input wire logic clear_all_in,
    input wire logic cmd_clear_one,
    input wire logic cmd_clear_all,
    input wire logic [aan_pkg::ALARM_IDX_W-1:0] cmd_alarm_sel,
    input wire logic key_back,
    input wire logic silence_in,
    input wire logic cmd_mute,
    input wire logic cmd_reset_latches,
    input wire logic key_any,
    input wire logic [aan_pkg::TIMEOUT_W-1:0] view_timeout_s,
    input wire logic led_test,
    input wire logic list_fixed,
    input wire logic [aan_pkg::OBJ_SEL_W-1:0] obj_select,
    input wire logic [aan_pkg::OBJ_COUNT-1:0] obj_closed,
    input wire logic [aan_pkg::OBJ_COUNT-1:0] obj_open,
    input wire logic fault_reset_in,
    input wire logic fault_capture,
    input wire logic protocol_en,
    output logic [aan_pkg::ALARM_COUNT-1:0] alarm_shown,
    output logic [aan_pkg::ALARM_COUNT-1:0] alarm_led,
    output logic [aan_pkg::COLOR_W-1:0] led_color,
    output logic [aan_pkg::ALARM_COUNT-1:0] list_valid,
    output logic [aan_pkg::ALARM_IDX_W*aan_pkg::ALARM_COUNT-1:0] list_order,
    output logic buzzer,
    output logic latch_reset_done,
    output logic default_view,
    output logic led_close,
    output logic led_open,
    output logic fault_valid,
    output logic rec_valid,
    output logic rec_raise,
    output logic [aan_pkg::ALARM_IDX_W-1:0] rec_alarm,
    output logic [aan_pkg::TS_W-1:0] rec_time,
    output logic proto_valid
);
    // ------------------------------------------------------------
    // Edge detection of requests
    // ------------------------------------------------------------
    localparam int NREQ = 7;
    logic [NREQ-1:0] req_lvl;
    logic [NREQ-1:0] req_rise;
    assign req_lvl = {fault_reset_in, cmd_reset_latches, key_back, silence_in, cmd_mute,
                      key_clear | clear_all_in | cmd_clear_all, cmd_clear_one};
    genvar gi;
    generate
        for (gi = 0; gi < NREQ; gi++) begin : g_edge
            aan_edge u_edge (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .level_in(req_lvl[gi]),
                .rise_out(req_rise[gi])
            );
        end
    endgenerate
    logic clr_one_p, clr_all_p, mute_p, silence_p, back_p, rlatch_p, fault_rst_p;
    assign clr_one_p = req_rise[0];
    assign clr_all_p = req_rise[1];
    assign mute_p = req_rise[2];
    assign silence_p = req_rise[3];
    assign back_p = req_rise[4];
    assign rlatch_p = req_rise[5];
    assign fault_rst_p = req_rise[6];

    // ------------------------------------------------------------
    // Millisecond tick and time stamp
    // ------------------------------------------------------------
    logic tick_ms;
    aan_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick_out(tick_ms)
    );

    // ------------------------------------------------------------
    // Source selection and latches
    // ------------------------------------------------------------
    logic [ALARM_COUNT-1:0] src_raw;
    logic [ALARM_COUNT-1:0] src_eff;
    logic [ALARM_COUNT-1:0] latch_reg, latch_next;
    logic back_seen_reg, back_seen_next;
    always_comb begin
        for (int i = 0; i < ALARM_COUNT; i++) begin
            src_raw[i] = src_signals[src_select[i*SRC_SEL_W +: SRC_SEL_W]];
        end
    end
    always_comb begin
        latch_next = latch_reg | (src_raw & src_latched);
        back_seen_next = back_seen_reg | back_p;
        if (rlatch_p && back_seen_reg) begin
            latch_next = src_raw & src_latched;
            back_seen_next = back_p;
        end else if (rlatch_p) begin
            latch_next = (latch_reg & src_latched) | (src_raw & src_latched);
        end
        for (int i = 0; i < ALARM_COUNT; i++) begin
            src_eff[i] = src_latched[i] ? latch_reg[i] | src_raw[i] : src_raw[i];
        end
    end

    // ------------------------------------------------------------
    // Alarm states and display list
    // ------------------------------------------------------------
    logic [ALARM_COUNT-1:0] prev_reg, prev_next;
    logic [ALARM_COUNT-1:0] shown_reg, shown_next;
    logic [ALARM_COUNT-1:0] rise_v, fall_v;
    logic [ALARM_COUNT-1:0] lvalid_reg, lvalid_next;
    logic [ALARM_IDX_W*ALARM_COUNT-1:0] lorder_reg, lorder_next;
    logic [ALARM_IDX_W:0] lcount_reg, lcount_next;
    always_comb begin
        rise_v = src_eff & ~prev_reg;
        fall_v = ~src_eff & prev_reg;
        prev_next = src_eff;
        shown_next = shown_reg | src_eff;
        if (clr_all_p) begin
            shown_next = shown_next & src_eff;
        end
        if (clr_one_p && !src_eff[cmd_alarm_sel]) begin
            shown_next[cmd_alarm_sel] = 1'b0;
        end
        lvalid_next = lvalid_reg;
        lorder_next = lorder_reg;
        lcount_next = lcount_reg;
        if (list_fixed) begin
            lvalid_next = '0;
            for (int i = 0; i < FIXED_SLOTS; i++) begin
                lvalid_next[i] = 1'b1;
                lorder_next[i*ALARM_IDX_W +: ALARM_IDX_W] = ALARM_IDX_W'(i);
            end
            lcount_next = '0;
        end else begin
            lcount_next = '0;
            lvalid_next = '0;
            for (int i = 0; i < ALARM_COUNT; i++) begin
                if (lvalid_reg[i] && shown_next[lorder_reg[i*ALARM_IDX_W +: ALARM_IDX_W]]) begin
                    lorder_next[lcount_next[ALARM_IDX_W-1:0]*ALARM_IDX_W +: ALARM_IDX_W] =
                        lorder_reg[i*ALARM_IDX_W +: ALARM_IDX_W];
                    lvalid_next[lcount_next[ALARM_IDX_W-1:0]] = 1'b1;
                    lcount_next = lcount_next + 1'b1;
                end
            end
            for (int i = 0; i < ALARM_COUNT; i++) begin
                if (rise_v[i] && !shown_reg[i] && lcount_next < (ALARM_IDX_W+1)'(ALARM_COUNT)) begin
                    lorder_next[lcount_next[ALARM_IDX_W-1:0]*ALARM_IDX_W +: ALARM_IDX_W] =
                        ALARM_IDX_W'(i);
                    lvalid_next[lcount_next[ALARM_IDX_W-1:0]] = 1'b1;
                    lcount_next = lcount_next + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Event records
    // ------------------------------------------------------------
    logic [ALARM_COUNT-1:0] pend_r_reg, pend_r_next, pend_f_reg, pend_f_next;
    logic [TS_W-1:0] ts_reg, ts_next;
    logic rv_next, rr_next, pv_next;
    logic [ALARM_IDX_W-1:0] ra_next;
    always_comb begin
        ts_next = tick_ms ? ts_reg + 32'h1 : ts_reg;
        pend_r_next = pend_r_reg | (rise_v & mask_raise);
        pend_f_next = pend_f_reg | (fall_v & mask_fall);
        rv_next = 1'b0;
        rr_next = 1'b0;
        ra_next = '0;
        for (int i = ALARM_COUNT - 1; i >= 0; i--) begin
            if (pend_f_reg[i]) begin
                rv_next = 1'b1;
                rr_next = 1'b0;
                ra_next = ALARM_IDX_W'(i);
            end
        end
        for (int i = ALARM_COUNT - 1; i >= 0; i--) begin
            if (pend_r_reg[i]) begin
                rv_next = 1'b1;
                rr_next = 1'b1;
                ra_next = ALARM_IDX_W'(i);
            end
        end
        if (rv_next && rr_next) begin
            pend_r_next[ra_next] = rise_v[ra_next] & mask_raise[ra_next];
        end else if (rv_next) begin
            pend_f_next[ra_next] = fall_v[ra_next] & mask_fall[ra_next];
        end
        pv_next = rv_next & protocol_en;
    end

    // ------------------------------------------------------------
    // Buzzer, blink, view timeout, objects, fault register
    // ------------------------------------------------------------
    logic buz_reg, buz_next;
    logic [9:0] blink_cnt_reg, blink_cnt_next;
    logic blink_reg, blink_next;
    logic [COLOR_W-1:0] col_reg, col_next, lcol_next;
    logic [TIMEOUT_W+10-1:0] idle_ms_reg, idle_ms_next;
    logic dview_reg, dview_next;
    logic lclose_next, lopen_next;
    logic fault_reg, fault_next;
    logic ldone_reg, ldone_next;
    logic [ALARM_COUNT-1:0] led_next;
    always_comb begin
        buz_next = buz_reg;
        if (mute_p || silence_p || back_p) begin
            buz_next = 1'b0;
        end
        if (|rise_v) begin
            buz_next = 1'b1;
        end
        blink_cnt_next = blink_cnt_reg;
        blink_next = blink_reg;
        col_next = col_reg;
        if (tick_ms) begin
            blink_cnt_next = blink_cnt_reg + 10'h1;
            if (blink_cnt_reg == 10'(BLINK_MS - 1)) begin
                blink_cnt_next = '0;
                blink_next = ~blink_reg;
                col_next = col_reg + 1'b1;
            end
        end
        for (int i = 0; i < ALARM_COUNT; i++) begin
            led_next[i] = src_eff[i] | (shown_next[i] & blink_reg);
        end
        if (led_test) begin
            led_next = '1;
        end
        idle_ms_next = idle_ms_reg;
        dview_next = dview_reg;
        if (key_any) begin
            idle_ms_next = '0;
            dview_next = 1'b0;
        end else if (view_timeout_s != TIMEOUT_OFF && tick_ms && !dview_reg) begin
            idle_ms_next = idle_ms_reg + 1'b1;
            if (idle_ms_reg + 1'b1 >= view_timeout_s * (TIMEOUT_W+10)'(MS_PER_S)) begin
                dview_next = 1'b1;
                idle_ms_next = '0;
            end
        end
        lclose_next = 1'b0;
        lopen_next = 1'b0;
        if (obj_select < OBJ_SEL_W'(OBJ_COUNT)) begin
            lclose_next = obj_closed[obj_select];
            lopen_next = obj_open[obj_select];
        end
        if (led_test) begin
            lclose_next = 1'b1;
            lopen_next = 1'b1;
        end
        fault_next = fault_reg | fault_capture;
        if (fault_rst_p) begin
            fault_next = fault_capture;
        end
        ldone_next = rlatch_p;
        lcol_next = led_test ? col_reg : '0;
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            latch_reg <= '0;
            back_seen_reg <= 1'b0;
            prev_reg <= '0;
            shown_reg <= '0;
            lvalid_reg <= '0;
            lorder_reg <= '0;
            lcount_reg <= '0;
            pend_r_reg <= '0;
            pend_f_reg <= '0;
            ts_reg <= '0;
            rec_valid <= 1'b0;
            rec_raise <= 1'b0;
            rec_alarm <= '0;
            rec_time <= '0;
            proto_valid <= 1'b0;
            buz_reg <= 1'b0;
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
            col_reg <= '0;
            idle_ms_reg <= '0;
            dview_reg <= 1'b0;
            led_close <= 1'b0;
            led_open <= 1'b0;
            fault_reg <= 1'b0;
            ldone_reg <= 1'b0;
            alarm_led <= '0;
            led_color <= '0;
        end else begin
            latch_reg <= latch_next;
            back_seen_reg <= back_seen_next;
            prev_reg <= prev_next;
            shown_reg <= shown_next;
            lvalid_reg <= lvalid_next;
            lorder_reg <= lorder_next;
            lcount_reg <= lcount_next;
            pend_r_reg <= pend_r_next;
            pend_f_reg <= pend_f_next;
            ts_reg <= ts_next;
            rec_valid <= rv_next;
            rec_raise <= rr_next;
            rec_alarm <= ra_next;
            rec_time <= ts_reg;
            proto_valid <= pv_next;
            buz_reg <= buz_next;
            blink_cnt_reg <= blink_cnt_next;
            blink_reg <= blink_next;
            col_reg <= col_next;
            idle_ms_reg <= idle_ms_next;
            dview_reg <= dview_next;
            led_close <= lclose_next;
            led_open <= lopen_next;
            fault_reg <= fault_next;
            ldone_reg <= ldone_next;
            alarm_led <= led_next;
            led_color <= lcol_next;
        end
    end
    assign alarm_shown = shown_reg;
    assign list_valid = lvalid_reg;
    assign list_order = lorder_reg;
    assign buzzer = buz_reg;
    assign default_view = dview_reg;
    assign fault_valid = fault_reg;
    assign latch_reset_done = ldone_reg;
endmodule

// ### verification/aan_chk.sv
// Checker of the alarm annunciator core ports
`timescale 1ns/10ps
module aan_chk
    import aan_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [aan_pkg::SRC_COUNT-1:0] src_signals,
    input wire logic [aan_pkg::SRC_SEL_W*aan_pkg::ALARM_COUNT-1:0] src_select,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] src_latched,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] mask_raise,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] mask_fall,
    input wire logic key_clear,
    input wire logic clear_all_in,
    input wire logic cmd_clear_all,
    input wire logic cmd_clear_one,
    input wire logic [aan_pkg::ALARM_IDX_W-1:0] cmd_alarm_sel,
    input wire logic key_back,
    input wire logic silence_in,
    input wire logic cmd_mute,
    input wire logic led_test,
    input wire logic [aan_pkg::OBJ_SEL_W-1:0] obj_select,
    input wire logic [aan_pkg::OBJ_COUNT-1:0] obj_closed,
    input wire logic [aan_pkg::OBJ_COUNT-1:0] obj_open,
    input wire logic fault_reset_in,
    input wire logic fault_capture,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] alarm_shown,
    input wire logic [aan_pkg::ALARM_COUNT-1:0] alarm_led,
    input wire logic buzzer,
    input wire logic led_close,
    input wire logic led_open,
    input wire logic fault_valid,
    input wire logic rec_valid,
    input wire logic rec_raise,
    input wire logic [aan_pkg::ALARM_IDX_W-1:0] rec_alarm
);
    // ----------------------------------------
    // Alarm 0 source and request lines
    // ----------------------------------------
    logic src0;
    logic clr;
    logic sil;
    assign src0 = src_signals[src_select[6:0]];
    assign clr = key_clear | clear_all_in | cmd_clear_all;
    assign sil = key_back | silence_in | cmd_mute;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_raise0;
        ##[2:8] (rec_valid && rec_raise && rec_alarm == 6'h00);
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_SHOW_ON: assert property (src0 |=> alarm_shown[0])
        else $error("alarm not shown while source high");
    AST_LED_ON: assert property (src0 |=> alarm_led[0])
        else $error("alarm led off while source high");
    AST_SHOW_HOLD: assert property (alarm_shown[0] && !$rose(clr)
        && !($rose(cmd_clear_one) && cmd_alarm_sel == 6'h00) |=> alarm_shown[0])
        else $error("alarm dropped without clear");
    AST_CLR_ALL: assert property ($rose(clr) && !src0 && !$past(src0)
        && !src_latched[0] |=> !alarm_shown[0])
        else $error("clear all left inactive alarm");
    AST_CLR_ONE: assert property ($rose(cmd_clear_one) && cmd_alarm_sel == 6'h00
        && !src0 && !$past(src0) && !src_latched[0] |=> !alarm_shown[0])
        else $error("single clear ignored");
    AST_REC: assert property ($rose(src0) && !alarm_shown[0] && mask_raise[0]
        |-> s_raise0)
        else $error("raise record missing");
    AST_REC_MASK: assert property (rec_valid
        |-> (rec_raise ? mask_raise[rec_alarm] : mask_fall[rec_alarm]))
        else $error("record written against mask");
    AST_BUZZ_ON: assert property ($rose(src0) && !alarm_shown[0] |=> buzzer)
        else $error("buzzer not raised");
    AST_BUZZ_OFF: assert property ($rose(sil) && $stable(src_signals) |=> !buzzer)
        else $error("buzzer not silenced");
    AST_LED_TEST: assert property (led_test && $past(led_test) |-> &alarm_led)
        else $error("led test left a led dark");
    AST_OBJ: assert property ($past(nrst) && !led_test && !$past(led_test)
        && $stable(obj_select) && $stable(obj_closed) && $stable(obj_open)
        && obj_select < 4'ha |-> led_close == obj_closed[obj_select]
        && led_open == obj_open[obj_select])
        else $error("object leds wrong");
    AST_FAULT: assert property ($rose(fault_reset_in) && !fault_capture |=> !fault_valid)
        else $error("fault register not cleared");
endmodule
bind aan_top aan_chk aan_chk_inst (.*);

// ### verification/aan_panel.sv
// Front panel and source model driving operator keys and source levels
`timescale 1ns/10ps
module aan_panel (
    input wire logic clk_sys,
    output logic [8:0] keys,
    output logic [127:0] srcs
);
    initial begin
        keys = 9'h000;
        srcs = 128'h0;
    end
    // Key held three cycles
    task automatic press(input int k);
        @(negedge clk_sys);
        keys[k] = 1'b1;
        repeat (3) @(negedge clk_sys);
        keys[k] = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic set_src(input logic [127:0] m, input logic v);
        @(negedge clk_sys);
        srcs = v ? (srcs | m) : (srcs & ~m);
    endtask
endmodule

// ### verification/aan_top_tb.sv
// Testbench of the alarm annunciator core
`timescale 1ns/10ps
module aan_top_tb;
    import aan_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [SRC_SEL_W*ALARM_COUNT-1:0] src_select;
    logic [ALARM_COUNT-1:0] src_latched, mask_raise, mask_fall;
    logic [ALARM_IDX_W-1:0] cmd_alarm_sel;
    logic [TIMEOUT_W-1:0] view_timeout_s;
    logic led_test, list_fixed, fault_reset_in, fault_capture, protocol_en;
    logic [OBJ_SEL_W-1:0] obj_select;
    logic [OBJ_COUNT-1:0] obj_closed, obj_open;
    logic [8:0] keys;
    logic [SRC_COUNT-1:0] srcs;
    logic [ALARM_COUNT-1:0] alarm_shown, alarm_led, list_valid;
    logic [COLOR_W-1:0] led_color;
    logic [ALARM_IDX_W*ALARM_COUNT-1:0] list_order;
    logic buzzer, latch_reset_done, default_view, led_close, led_open;
    logic fault_valid, rec_valid, rec_raise, proto_valid;
    logic [ALARM_IDX_W-1:0] rec_alarm;
    logic [TS_W-1:0] rec_time;
    logic [6:0] recs[$];
    int n_fail = 0;
    int total_checks = 0;
    int n_rec = 0;
    int n_proto = 0;
    int n_ldone = 0;
    logic [TS_W-1:0] last_ts;
    int cycles = 0;
    int nch;
    aan_panel aan_panel_inst (.clk_sys(clk_sys), .keys(keys), .srcs(srcs));
    aan_top #(.TICK_DIV(10)) aan_top_inst (.*, .src_signals(srcs), .key_clear(keys[0]),
        .clear_all_in(keys[1]), .cmd_clear_all(keys[2]), .cmd_clear_one(keys[3]),
        .key_back(keys[4]), .silence_in(keys[5]), .cmd_mute(keys[6]),
        .cmd_reset_latches(keys[7]), .key_any(keys[8]));
    always #4 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Record monitor and cycle ceiling
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (rec_valid === 1'b1) begin
            recs.push_back({rec_raise, rec_alarm});
            n_rec++;
            last_ts = rec_time;
        end
        if (proto_valid === 1'b1) begin
            n_proto++;
        end
        if (latch_reset_done === 1'b1) begin
            n_ldone++;
        end
        if (cycles == 60000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic getrec(input logic [6:0] exp);
        int n;
        n = 0;
        while (recs.size() == 0 && n < 100) begin
            @(negedge clk_sys);
            n++;
        end
        if (recs.size() == 0) begin
            recs.push_back(7'hx);
        end
        chk(64'(recs.pop_front()), 64'(exp));
    endtask
    task automatic watch(input bit col);
        logic [1:0] prev, cur;
        nch = 0;
        prev = col ? led_color : {1'b0, alarm_led[0]};
        repeat (6000) begin
            @(negedge clk_sys);
            cur = col ? led_color : {1'b0, alarm_led[0]};
            if (cur !== prev) nch++;
            prev = cur;
        end
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        src_latched = 64'h4000_0000;
        mask_raise = ~64'h10_0000;
        mask_fall = 64'h10_0000;
        {cmd_alarm_sel, view_timeout_s, obj_select} = 22'h0;
        {led_test, list_fixed, fault_reset_in, fault_capture, protocol_en} = 5'h01;
        obj_closed = 10'h001;
        obj_open = 10'h008;
        for (int i = 0; i < ALARM_COUNT; i++) src_select[SRC_SEL_W*i +: SRC_SEL_W] = 7'(i);
        repeat (20) @(negedge clk_sys);
        nrst = 1'b1;
        cyc(2);
        aan_panel_inst.set_src(128'h3, 1'b1);
        cyc(2);
        chk(alarm_shown, 64'h3);
        chk(alarm_led, 64'h3);
        chk(buzzer, 64'h1);
        getrec(7'h40);
        getrec(7'h41);
        aan_panel_inst.set_src(128'h1, 1'b0);
        watch(1'b0);
        chk(nch > 1, 64'h1);
        chk(alarm_shown, 64'h3);
        aan_panel_inst.press(0);
        chk(alarm_shown, 64'h2);
        aan_panel_inst.set_src(128'h2, 1'b0);
        aan_panel_inst.press(1);
        chk(alarm_shown, 64'h0);
        aan_panel_inst.set_src(128'h9, 1'b1);
        aan_panel_inst.set_src(128'h9, 1'b0);
        aan_panel_inst.press(3);
        chk(alarm_shown, 64'h8);
        aan_panel_inst.set_src(128'h8, 1'b1);
        cmd_alarm_sel = 6'h03;
        aan_panel_inst.press(3);
        chk(alarm_shown, 64'h8);
        aan_panel_inst.press(2);
        chk(alarm_shown, 64'h8);
        aan_panel_inst.set_src(128'h8, 1'b0);
        aan_panel_inst.press(2);
        chk(alarm_shown, 64'h0);
        for (int k = 4; k < 7; k++) begin
            aan_panel_inst.set_src(128'h1 << (10 + k), 1'b1);
            cyc(2);
            chk(buzzer, 64'h1);
            aan_panel_inst.press(k);
            chk(buzzer, 64'h0);
        end
        aan_panel_inst.set_src(128'h1_c000, 1'b0);
        aan_panel_inst.press(0);
        recs.delete();
        aan_panel_inst.set_src(128'h10_0000, 1'b1);
        cyc(20);
        chk(recs.size(), 64'h0);
        protocol_en = 1'b0;
        aan_panel_inst.set_src(128'h10_0000, 1'b0);
        getrec(7'h14);
        protocol_en = 1'b1;
        chk(last_ts > 0, 64'h1);
        aan_panel_inst.press(0);
        aan_panel_inst.press(7);
        aan_panel_inst.set_src(128'h4000_0000, 1'b1);
        aan_panel_inst.set_src(128'h4000_0000, 1'b0);
        aan_panel_inst.press(0);
        chk(alarm_shown[30], 64'h1);
        aan_panel_inst.press(7);
        aan_panel_inst.press(0);
        chk(alarm_shown[30], 64'h1);
        aan_panel_inst.press(4);
        aan_panel_inst.press(7);
        aan_panel_inst.press(0);
        chk(alarm_shown, 64'h0);
        chk(n_ldone, 64'h3);
        led_test = 1'b1;
        cyc(3);
        chk(alarm_led, 64'hffff_ffff_ffff_ffff);
        watch(1'b1);
        chk(nch > 1, 64'h1);
        led_test = 1'b0;
        list_fixed = 1'b1;
        cyc(3);
        chk(list_valid, 64'hffff);
        list_fixed = 1'b0;
        cyc(3);
        chk(list_valid, 64'h0);
        aan_panel_inst.set_src(128'h20, 1'b1);
        aan_panel_inst.set_src(128'h80, 1'b1);
        cyc(2);
        chk(list_valid, 64'h3);
        chk(list_order[11:0], 64'h1c5);
        chk({led_close, led_open}, 64'h2);
        obj_select = 4'h3;
        obj_closed = 10'h009;
        cyc(3);
        chk({led_close, led_open}, 64'h3);
        fault_capture = 1'b1;
        cyc(1);
        fault_capture = 1'b0;
        cyc(2);
        chk(fault_valid, 64'h1);
        fault_reset_in = 1'b1;
        cyc(2);
        chk(fault_valid, 64'h0);
        fault_reset_in = 1'b0;
        view_timeout_s = 12'h001;
        aan_panel_inst.press(8);
        cyc(5000);
        chk(default_view, 64'h0);
        cyc(6000);
        chk(default_view, 64'h1);
        view_timeout_s = 12'h000;
        aan_panel_inst.press(8);
        cyc(11000);
        chk(default_view, 64'h0);
        chk(n_proto, n_rec - 1);
        end_of_test();
    end
endmodule
